// File: ssc_regs.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 byte-wide synchronous serial port. Assumes inclusion by bare name.
*/
// Summary of operation
// - Transmit buffer writes ignored while flag is 0
// - Internal clock drives pin, high outside transfers
// - Internal clock halts until buffer serviced
// - Clock resumes within one serial period
// - Clock select codes give fixed divisors; with the low-speed option bit set, codes 001 to 110 give no clock
// - Code 111 takes external clock, pin undriven
// - Transmit shifts on clock pin falling edge
// - Receive samples on clock pin rising edge
// - One bit-order control for both directions
// - Bit order 0 sends bit 7 first
// - Bit order 1 sends bit 0 first
// - Mode field picks transmit, receive or both
// - Modes 00 transmit, 01 receive, 10 both
// - Busy flag 1 during transfer, else 0
// - Transmit buffer write clears empty flag
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

`define SSC_OFS_BUF        8'h2b
`define SSC_OFS_CTRL       8'h31
`define SSC_OFS_STAT       8'h32
`define SSC_OFS_OPT        8'h33

`define SSC_CTRL_START     7
`define SSC_CTRL_INH       6
`define SSC_CTRL_MODE_LSB  4
`define SSC_CTRL_DIR       3
`define SSC_CTRL_SEL_LSB   0

`define SSC_STAT_BUSY      7
`define SSC_STAT_SEF       6
`define SSC_STAT_TXF       5
`define SSC_STAT_RXF       4
`define SSC_STAT_TXERR     3
`define SSC_STAT_RXERR     2

`define SSC_OPT_PRESRC     0
`define SSC_OPT_LOWSPD     1

`define SSC_CTRL_RST       8'h00
`define SSC_RXBUF_RST      8'h00
`define SSC_OPT_RST        2'h0

`define SSC_SEL_SLOW       3'h0
`define SSC_SEL_EXT        3'h7
`define SSC_BITS           4'h8
`define SSC_LS_HALF_LAST   3'h7
`define SSC_MAX_PERIOD     13'h1000

`endif

// File: ssc_pkg.sv
/*
 Types of the synchronous serial port. Assumes nothing of its surroundings.
*/
package ssc_pkg;

   typedef logic [7:0] ssc_byte_t;

   typedef enum logic [1:0] {
      SSC_MODE_TX   = 2'b00,
      SSC_MODE_RX   = 2'b01,
      SSC_MODE_TXRX = 2'b10,
      SSC_MODE_RSV  = 2'b11
   } ssc_mode_t;

   typedef enum logic [1:0] {
      SSC_ST_IDLE  = 2'b00,
      SSC_ST_SHIFT = 2'b01,
      SSC_ST_WAIT  = 2'b10
   } ssc_state_t;

endpackage

// File: ssc_clk_if.sv
/*
 Signals between the serial core and its clock divider.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
interface ssc_clk_if;
   logic [2:0] sel;
   logic       slow_src;
   logic       fs_edge;
   logic       fall_tick;
   logic       rise_tick;

   modport gen  (input sel, input slow_src, input fs_edge, output fall_tick, output rise_tick);
   modport core (output sel, output slow_src, output fs_edge, input fall_tick, input rise_tick);
endinterface

// File: ssc_clkgen.sv
/*
 Free-running serial clock divider: alternating fall and rise ticks, one
 tick per half period of the selected rate, so one fall and one rise per period.
 Assumes clk_i is the high-speed clock fc and fs_edge marks low-speed edges.
*/
`timescale 1ns/1ns
`include "ssc_regs.svh"
module ssc_clkgen (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic ce_i,
   ssc_clk_if.gen    cif
);
   import ssc_pkg::*;

   logic [11:0] cnt;
   logic        phase;
   logic        wrap;
   logic        slow;

   // Last count of a half period for fc divided by 2^n
   function automatic logic [11:0] half_last(input logic [2:0] sel);
      case (sel)
         3'h0:    half_last = 12'h7ff;
         3'h1:    half_last = 12'h07f;
         3'h2:    half_last = 12'h03f;
         3'h3:    half_last = 12'h01f;
         3'h4:    half_last = 12'h00f;
         3'h5:    half_last = 12'h007;
         default: half_last = 12'h003;
      endcase
   endfunction

   assign slow = (cif.sel == `SSC_SEL_SLOW) && cif.slow_src;
   assign wrap = (cif.sel != `SSC_SEL_EXT) &&
                 (slow ? (cif.fs_edge && cnt[2:0] == `SSC_LS_HALF_LAST)
                       : (cnt >= half_last(cif.sel)));

   // fc/4096..fc/8, or fs/16 on the slow source
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt   <= 12'h000;
         phase <= 1'b0;
      end else if (ce_i) begin
         if (wrap) begin
            cnt   <= 12'h000;
            phase <= ~phase;
         end else if (!slow || cif.fs_edge) begin
            cnt <= cnt + 12'h001;
         end
      end
   end

   assign cif.fall_tick = wrap && !phase;
   assign cif.rise_tick = wrap && phase;
endmodule // ssc_clkgen

// File: ssc_core.sv
/*
 Byte-wide synchronous serial port: buffers, control and status registers,
 clock select, shift engine and pin drive.
 Assumes a plain register port with read data one cycle after the strobe,
 and pins that pass through three-flop synchronisers.
*/
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`include "ssc_regs.svh"
module ssc_core (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             ce_i,
   input  wire logic [7:0]       addr_i,
   input  wire ssc_pkg::ssc_byte_t wr_data_i,
   input  wire logic             wr_en_i,
   input  wire logic             rd_en_i,
   output ssc_pkg::ssc_byte_t    rd_data_o,
   input  wire logic             lsclk_i,
   input  wire logic             sck_i,
   output logic                  sck_o,
   output logic                  sck_oe_o,
   input  wire logic             si_i,
   output logic                  so_o
);
   import ssc_pkg::*;

   ssc_clk_if cif ();

   ssc_clkgen u_clkgen (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .ce_i    (ce_i),
      .cif     (cif)
   );

   // Control and option state
   logic       ctrl_start;
   ssc_mode_t  ctrl_mode;
   logic       ctrl_dir;
   logic [2:0] ctrl_sel;
   logic [1:0] opt;

   // Buffers and flags
   ssc_byte_t  txbuf;
   ssc_byte_t  rxbuf;
   logic       transmit_buffer_empty_flag;
   logic       rxf;
   logic       txerr;
   logic       rxerr;

   // Engine
   ssc_state_t state;
   ssc_byte_t  sh;
   logic [3:0] bitcnt;
   logic       sck_q;
   logic       so_q;

   // Pin synchronisers: sck, si, lsclk
   logic [2:0] s1;
   logic [2:0] s2;
   logic [2:0] s3;
   logic [2:0] flt;

   // Decodes
   logic wr_buf;
   logic wr_ctrl;
   logic wr_stat;
   logic rd_buf;
   logic inh;
   logic ext;
   logic rate_rsv;
   logic need_tx;
   logic need_rx;
   logic ready;
   logic ext_fall;
   logic ext_rise;
   logic ev_fall;
   logic ev_rise;
   logic start_ok;
   logic load_tx;
   logic txerr_ev;
   logic done;
   logic rx_store;
   logic rxerr_ev;
   logic out_bit;
   logic si_f;
   ssc_byte_t sh_in;

   assign wr_buf  = wr_en_i && addr_i == `SSC_OFS_BUF;
   assign wr_ctrl = wr_en_i && addr_i == `SSC_OFS_CTRL;
   assign wr_stat = wr_en_i && addr_i == `SSC_OFS_STAT;
   assign rd_buf  = rd_en_i && addr_i == `SSC_OFS_BUF;
   assign inh     = wr_ctrl && wr_data_i[`SSC_CTRL_INH];

   assign ext      = ctrl_sel == `SSC_SEL_EXT;
   assign rate_rsv = opt[`SSC_OPT_LOWSPD] && !ext && ctrl_sel != `SSC_SEL_SLOW;
   assign need_tx  = ctrl_mode == SSC_MODE_TX || ctrl_mode == SSC_MODE_TXRX;
   assign need_rx  = ctrl_mode == SSC_MODE_RX || ctrl_mode == SSC_MODE_TXRX;
   assign ready    = (!need_tx || !transmit_buffer_empty_flag) && (!need_rx || !rxf);

   assign cif.sel      = ctrl_sel;
   assign cif.slow_src = opt[`SSC_OPT_PRESRC] || opt[`SSC_OPT_LOWSPD];
   assign cif.fs_edge  = s3[2] == s2[2] && s2[2] && !flt[2];

   assign ext_fall = s2[0] == s3[0] && !s2[0] && flt[0];
   assign ext_rise = s2[0] == s3[0] && s2[0] && !flt[0];
   assign ev_fall  = ext ? ext_fall : (cif.fall_tick && !rate_rsv);
   assign ev_rise  = ext ? ext_rise : (cif.rise_tick && !rate_rsv);

   assign start_ok = ctrl_start && ctrl_mode != SSC_MODE_RSV && ev_fall &&
                     state != SSC_ST_SHIFT && (ext || ready) && !inh;
   assign load_tx  = start_ok && need_tx && !transmit_buffer_empty_flag;
   assign txerr_ev = start_ok && need_tx && transmit_buffer_empty_flag;
   assign done     = state == SSC_ST_SHIFT && ev_rise && bitcnt == `SSC_BITS && !inh;
   assign rx_store = done && need_rx && !rxf && !rxerr;
   assign rxerr_ev = done && need_rx && rxf;

   // One order control steers both directions
   assign out_bit = ctrl_dir ? sh[0] : sh[7];
   // Data in counts as soon as stages two and three agree; the filtered
   // copy lags one more cycle, too late for a fc/8 half period
   assign si_f    = (s2[1] == s3[1]) ? s2[1] : flt[1];
   assign sh_in   = ctrl_dir ? {si_f, sh[7:1]} : {sh[6:0], si_f};

   // Pin synchronisers; a change counts once stages two and three agree
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1  <= 3'h7;
         s2  <= 3'h7;
         s3  <= 3'h7;
         flt <= 3'h7;
      end else if (ce_i) begin
         s1 <= {lsclk_i, si_i, sck_i};
         s2 <= s1;
         s3 <= s2;
         for (int i = 0; i < 3; i++) begin
            if (s2[i] == s3[i]) begin
               flt[i] <= s2[i];
            end
         end
      end
   end

   // Control and option registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_start <= 1'b0;
         ctrl_mode  <= SSC_MODE_TX;
         ctrl_dir   <= 1'b0;
         ctrl_sel   <= 3'h0;
         opt <= `SSC_OPT_RST;
      end else if (ce_i) begin
         if (inh) begin
            ctrl_start <= 1'b0;
         end else if (wr_ctrl) begin
            ctrl_start <= wr_data_i[`SSC_CTRL_START];
            ctrl_mode  <= ssc_mode_t'(wr_data_i[`SSC_CTRL_MODE_LSB +: 2]);
            ctrl_dir   <= wr_data_i[`SSC_CTRL_DIR];
            ctrl_sel   <= wr_data_i[`SSC_CTRL_SEL_LSB +: 3];
         end
         if (wr_en_i && addr_i == `SSC_OFS_OPT) begin
            opt <= wr_data_i[1:0];
         end
      end
   end

   // Transmit buffer: accepted only while empty
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         txbuf <= 8'h00;
         transmit_buffer_empty_flag   <= 1'b1;
      end else if (ce_i) begin
         if (inh) begin
            txbuf <= 8'h00;
            transmit_buffer_empty_flag   <= 1'b1;
         end else if (wr_buf && transmit_buffer_empty_flag) begin
            txbuf <= wr_data_i;
            transmit_buffer_empty_flag   <= 1'b0;
         end else if (load_tx) begin
            transmit_buffer_empty_flag <= 1'b1;
         end
      end
   end

   // Receive buffer; a new byte wins over a read that clears the flag
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rxbuf <= `SSC_RXBUF_RST;
         rxf   <= 1'b0;
      end else if (ce_i) begin
         if (inh) begin
            rxbuf <= `SSC_RXBUF_RST;
            rxf   <= 1'b0;
         end else if (rx_store) begin
            rxbuf <= sh_in;
            rxf   <= 1'b1;
         end else if (rd_buf && !rxerr) begin
            rxf <= 1'b0;
         end
      end
   end

   // Error flags: cleared by writing 0, an error in the same cycle wins
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         txerr <= 1'b0;
         rxerr <= 1'b0;
      end else if (ce_i) begin
         if (inh) begin
            txerr <= 1'b0;
            rxerr <= 1'b0;
         end else begin
            if (txerr_ev) begin
               txerr <= 1'b1;
            end else if (wr_stat && !wr_data_i[`SSC_STAT_TXERR]) begin
               txerr <= 1'b0;
            end
            if (rxerr_ev) begin
               rxerr <= 1'b1;
            end else if (wr_stat && !wr_data_i[`SSC_STAT_RXERR]) begin
               rxerr <= 1'b0;
            end
         end
      end
   end

   // Shift engine
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state  <= SSC_ST_IDLE;
         sh     <= 8'h00;
         bitcnt <= 4'h0;
         sck_q  <= 1'b1;
         so_q   <= 1'b1;
      end else if (ce_i) begin
         if (inh) begin
            state <= SSC_ST_IDLE;
            sck_q <= 1'b1;
            so_q  <= 1'b1;
         end else begin
            unique case (state)
               SSC_ST_IDLE, SSC_ST_WAIT: begin
                  sck_q <= 1'b1;
                  if (start_ok) begin
                     state  <= SSC_ST_SHIFT;
                     bitcnt <= 4'h1;
                     sck_q  <= 1'b0;
                     if (load_tx) begin
                        sh   <= txbuf;
                        so_q <= ctrl_dir ? txbuf[0] : txbuf[7];
                     end else begin
                        so_q <= 1'b1;
                     end
                  end else if (state == SSC_ST_WAIT && !ctrl_start) begin
                     state <= SSC_ST_IDLE;
                     so_q  <= 1'b1;
                  end
               end
               SSC_ST_SHIFT: begin
                  if (ev_rise) begin
                     sck_q <= 1'b1;
                     sh    <= sh_in;
                     if (bitcnt == `SSC_BITS) begin
                        state <= ctrl_start ? SSC_ST_WAIT : SSC_ST_IDLE;
                        if (!ctrl_start) begin
                           so_q <= 1'b1;
                        end
                     end
                  end else if (ev_fall) begin
                     sck_q  <= 1'b0;
                     bitcnt <= bitcnt + 4'h1;
                     so_q   <= (need_tx && !txerr) ? out_bit : 1'b1;
                  end
               end
               default: begin
                  state <= SSC_ST_IDLE;
               end
            endcase
         end
      end
   end

   // Register read port, data one cycle after the strobe
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_o <= 8'h00;
      end else if (ce_i) begin
         rd_data_o <= 8'h00;
         if (rd_en_i) begin
            unique case (addr_i)
               `SSC_OFS_BUF:  rd_data_o <= rxbuf;
               `SSC_OFS_CTRL: rd_data_o <= {ctrl_start, 1'b0, ctrl_mode, ctrl_dir, ctrl_sel};
               `SSC_OFS_STAT: rd_data_o <= {state != SSC_ST_IDLE, state == SSC_ST_SHIFT,
                                            transmit_buffer_empty_flag, rxf, txerr, rxerr, 2'b00};
               `SSC_OFS_OPT:  rd_data_o <= {6'h00, opt};
               default:       rd_data_o <= 8'h00;
            endcase
         end
      end
   end

   assign sck_o    = sck_q;
   assign sck_oe_o = !ext;
   assign so_o     = so_q;

   // Cycles spent waiting with the buffers serviced
   logic [12:0] wait_cnt;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_cnt <= 13'h0000;
      end else if (ce_i) begin
         // The fs-based rate is left out: its period follows the low-speed pin
         if (state == SSC_ST_WAIT && ready && ctrl_start && !ext && !rate_rsv &&
             !(ctrl_sel == `SSC_SEL_SLOW && cif.slow_src)) begin
            wait_cnt <= wait_cnt + 13'h0001;
         end else begin
            wait_cnt <= 13'h0000;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_TXW_IGNORED: assert property (ce_i && wr_buf && !transmit_buffer_empty_flag && !inh |=> $stable(txbuf))
      else $error("transmit buffer changed by a write while full");
   AST_SCK_IDLE_HIGH: assert property (state != SSC_ST_SHIFT |-> sck_o)
      else $error("serial clock low outside a transfer");
   AST_EXT_NO_DRIVE: assert property (ctrl_sel == 3'h7 |-> !sck_oe_o)
      else $error("clock pin driven with external clock selected");
   AST_AUTOWAIT: assert property (ce_i && state == SSC_ST_WAIT && !ready && !ext
                                  |=> state != SSC_ST_SHIFT)
      else $error("shift started before buffers were serviced");
   AST_RESUME: assert property (wait_cnt <= `SSC_MAX_PERIOD)
      else $error("serial clock did not resume within one period");
   AST_TXF_CLEAR: assert property (ce_i && wr_buf && transmit_buffer_empty_flag && !inh |=> !transmit_buffer_empty_flag)
      else $error("empty flag not cleared by a buffer write");
   AST_MSB_FIRST: assert property (ce_i && load_tx && !ctrl_dir
                                   |=> so_o == $past(txbuf[7]))
      else $error("first bit is not bit 7");
   AST_LSB_FIRST: assert property (ce_i && load_tx && ctrl_dir
                                   |=> so_o == $past(txbuf[0]))
      else $error("first bit is not bit 0");
   AST_RX_ONLY_IDLE_OUT: assert property (state == SSC_ST_SHIFT && ctrl_mode == SSC_MODE_RX
                                          |-> so_o)
      else $error("data out toggled in receive-only mode");
   AST_BUSY_END: assert property (ce_i && done && !ctrl_start && !inh
                                  |=> state == SSC_ST_IDLE)
      else $error("busy flag still set after the last byte");
   AST_RD_BUF: assert property (ce_i && rd_buf |=> rd_data_o == $past(rxbuf))
      else $error("buffer read did not return the receive buffer");
   AST_FALL_EDGE: assert property (ce_i && !ext && state == SSC_ST_SHIFT && ev_fall && !ev_rise
                                   && !inh |=> !sck_o)
      else $error("clock pin not low after a leading edge");

   COV_TX_BYTE: cover property (done && ctrl_mode == SSC_MODE_TX);
   COV_RX_STORE: cover property (rx_store);
   COV_TXERR: cover property (txerr_ev);
   COV_AUTOWAIT: cover property (state == SSC_ST_WAIT && !ready ##1 ready);
endmodule // ssc_core

// File: ssc_peer.sv
/*
 Behavioural model of the external serial device: captures the data-out pin
 on each rising clock edge, drives a fixed pattern on data-in at each
 falling edge, and can supply the clock itself for external-clock frames.
 Assumes the bench resolves the clock line from both drivers.
*/
`timescale 1ns/1ns
module ssc_peer #(
   parameter logic [7:0] PAT = 8'hb1
) (
   input  wire logic       sck_i,
   input  wire logic       so_i,
   output logic            sck_o,
   output logic            si_o,
   output logic [7:0]      rx_o,
   output int              cnt_o
);
   int idx;

   initial begin
      sck_o = 1'b1;
      si_o  = 1'b1;
      rx_o  = 8'h00;
      cnt_o = 0;
      idx   = 0;
   end

   task automatic clear();
      rx_o  = 8'h00;
      cnt_o = 0;
      idx   = 0;
   endtask

   // Clock stands high outside frames; phases never shorter than 4/fc
   task automatic clock_byte(input time half);
      repeat (8) begin
         sck_o = 1'b0;
         #half;
         sck_o = 1'b1;
         #half;
      end
   endtask

   always @(negedge sck_i) begin
      si_o = PAT[7 - (idx % 8)];
      idx  = idx + 1;
   end

   always @(posedge sck_i) begin
      rx_o  = {rx_o[6:0], so_i};
      cnt_o = cnt_o + 1;
   end

   // Hold time over: stop showing the last bit
   always @(posedge sck_i) begin
      if (idx != 0 && idx % 8 == 0) begin
         #300;
         si_o = ~si_o;
      end
   end
endmodule // ssc_peer

// File: ssc_core_bench.sv
/*
 Self-checking bench of the serial port: register access tasks, clock rates,
 bit order in both directions, automatic wait, external clock and modes.
 Assumes the design files and the peer model are compiled first.
*/
`timescale 1ns/1ns
`include "ssc_regs.svh"
module ssc_core_bench;
   import ssc_pkg::*;
   logic      clk_i     = 1'b0;
   logic      rst_n_i   = 1'b0;
   logic      ce_i      = 1'b1;
   logic      lsclk_i   = 1'b0;
   logic      wr_en_i   = 1'b0;
   logic      rd_en_i   = 1'b0;
   logic [7:0] addr_i   = 8'h00;
   ssc_byte_t wr_data_i = 8'h00;
   ssc_byte_t rd_data_o;
   logic      sck_o;
   logic      sck_oe_o;
   logic      so_o;
   logic      peer_sck;
   logic      si_line;
   logic [7:0] peer_rx;
   wire       sck_line;
   ssc_byte_t d;
   time       t0;
   time       falls[$];
   int        n;
   int        err_total  = 0;
   int        num_checks = 0;
   logic [7:0] ra[4]    = '{`SSC_OFS_BUF, `SSC_OFS_CTRL, `SSC_OFS_STAT, 8'h40};
   logic [7:0] rv[4]    = '{8'h00, 8'h00, 8'h20, 8'h00};
   time       per[8]    = '{204800, 16000, 12800, 6400, 3200, 1600, 800, 400};

   assign sck_line = sck_oe_o ? sck_o : peer_sck;

   ssc_core i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
      .lsclk_i(lsclk_i), .sck_i(sck_line), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
      .si_i(si_line), .so_o(so_o));
   ssc_peer i_peer (.sck_i(sck_line), .so_i(so_o), .sck_o(peer_sck), .si_o(si_line),
      .rx_o(peer_rx), .cnt_o());

   always #25 clk_i = ~clk_i;
   always #500 lsclk_i = ~lsclk_i;
   always @(negedge sck_o) if (rst_n_i) falls.push_back($time);

   task automatic wr(input logic [7:0] a, input ssc_byte_t v);
      @(posedge clk_i);
      addr_i    <= a;
      wr_data_i <= v;
      wr_en_i   <= 1'b1;
      @(posedge clk_i);
      wr_en_i   <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output ssc_byte_t v);
      @(posedge clk_i);
      addr_i  <= a;
      rd_en_i <= 1'b1;
      @(posedge clk_i);
      rd_en_i <= 1'b0;
      @(negedge clk_i);
      v = rd_data_o;
   endtask

   task automatic chk8(input string nm, input ssc_byte_t exp, input ssc_byte_t got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_time(input string nm, input time lo, input time hi, input time got);
      num_checks++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("mismatch %s expected %0t..%0t seen %0t", nm, lo, hi, got);
      end
   endtask

   task automatic wait_fall(input int k);
      int w;
      w = 0;
      while (falls.size() < k && w < 20000) begin
         @(posedge clk_i);
         w++;
      end
      if (falls.size() < k) begin
         err_total++;
         $display("mismatch serial clock falls expected %0d seen %0d", k, falls.size());
      end
   endtask

   task automatic wait_rxf();
      ssc_byte_t s;
      s = 8'h00;
      for (int w = 0; w < 200 && s[`SSC_STAT_RXF] !== 1'b1; w++) rd(`SSC_OFS_STAT, s);
      if (s[`SSC_STAT_RXF] !== 1'b1) begin
         err_total++;
         $display("mismatch receive flag expected 1 seen %b", s[`SSC_STAT_RXF]);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #2000000;
      err_total++;
      print_verdict();
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(ra[i], d);
         chk8("reset value", rv[i], d);
      end
      chk8("idle pins", 8'h07, {5'h00, sck_o, sck_oe_o, so_o});
      wr(`SSC_OFS_BUF, 8'ha5);
      rd(`SSC_OFS_STAT, d);
      chk8("status after write", 8'h00, d);
      wr(`SSC_OFS_BUF, 8'h3c);
      rd(`SSC_OFS_BUF, d);
      chk8("shared read", 8'h00, d);
      $display("test registers done");

      for (int dir = 0; dir < 2; dir++) begin
         i_peer.clear();
         falls.delete();
         if (dir == 1) wr(`SSC_OFS_BUF, 8'h4d);
         wr(`SSC_OFS_CTRL, dir == 1 ? 8'hae : 8'ha6);
         wait_rxf();
         chk8("peer byte", dir == 1 ? 8'hb2 : 8'ha5, peer_rx);
         rd(`SSC_OFS_BUF, d);
         chk8("receive buffer", dir == 1 ? 8'h8d : 8'hb1, d);
         n = falls.size();
         repeat (64) @(posedge clk_i);
         chk8("falls in wait", 8'(n), 8'(falls.size()));
         chk8("clock in wait", 8'h01, {7'h00, sck_o});
         t0 = $time;
         wr(`SSC_OFS_BUF, 8'h00);
         wait_fall(n + 1);
         chk_time("resume", 0, 600, falls[n] - t0);
         wr(`SSC_OFS_CTRL, 8'h40);
      end
      $display("test bit order done");

      for (int i = 0; i < 8; i++) begin
         wr(`SSC_OFS_OPT, {7'h00, i == 1});
         wr(`SSC_OFS_BUF, 8'h55);
         falls.delete();
         t0 = $time;
         wr(`SSC_OFS_CTRL, 8'h80 | 8'(i < 2 ? 0 : i - 1));
         wait_fall(1);
         chk_time("first fall", 0, per[i] + 600, falls[0] - t0);
         rd(`SSC_OFS_STAT, d);
         chk8("busy", 8'h80, d & 8'h80);
         wait_fall(2);
         chk_time("period", per[i] - 100, per[i] + 100, falls[1] - falls[0]);
         chk8("clock drive", 8'h01, {7'h00, sck_oe_o});
         wr(`SSC_OFS_CTRL, 8'h40);
      end
      wr(`SSC_OFS_OPT, 8'h00);
      $display("test clock rates done");

      i_peer.clear();
      wr(`SSC_OFS_CTRL, 8'h97);
      @(negedge clk_i);
      chk8("external drive", 8'h00, {7'h00, sck_oe_o});
      repeat (10) @(negedge clk_i);
      i_peer.clock_byte(400);
      wait_rxf();
      rd(`SSC_OFS_BUF, d);
      chk8("external receive", 8'hb1, d);
      chk8("data out idle", 8'h01, {7'h00, so_o});
      wr(`SSC_OFS_CTRL, 8'h40);
      wr(`SSC_OFS_BUF, 8'h5a);
      falls.delete();
      wr(`SSC_OFS_CTRL, 8'hb6);
      repeat (100) @(posedge clk_i);
      chk8("reserved falls", 8'h00, 8'(falls.size()));
      rd(`SSC_OFS_STAT, d);
      chk8("reserved busy", 8'h00, d & 8'h80);
      wr(`SSC_OFS_CTRL, 8'h40);
      $display("test external and modes done");
      print_verdict();
   end
endmodule // ssc_core_bench
